// ===== shared/mbw_pkg.sv
// Constants, register map and carrier types of the Modbus RTU write master.
// Assumes a single 20 MHz clock and an AHB-Lite register port.
// Notes on behaviour
// - The slave station address is a register that resets to 1.
// - Line rate, stop bits and data bits are software settings; the serial pins suit either RS232 or RS485.
// - Command 05 sends a request forcing one coil on or off.
// - Command 06 sends a request presetting one holding register.
// - Command 15 sends a request forcing a run of coils whose length is the configured count.
// - Command 16 sends a request writing consecutive registers from the start address over the count.
// - Write data comes either from the automatic source images or from the fixed manual value.
// - The manual value is held as four bytes of hex data.
// - In a multi-coil write bit 0 of the pattern goes to the start coil, higher bits to following coils.
// - Expansion points use continuous numbering, so the point index selects the image bit directly.
// - Enable high starts the write; reset clears the status and disables the block and beats enable.
// - Status goes to 1 after a good exchange and to 0 after any failure.
// - The response timeout is set in tenths of a second, typically 5; no answer counts as failure.
package mbw_pkg;
    localparam int unsigned CLK_HZ = 20000000;
    localparam int unsigned TENTH_S = 100;
    localparam int unsigned TENTH_CYCLES = CLK_HZ / 1000 * TENTH_S;
    // ************************************************************
    // Register map
    // ************************************************************
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_IRQ_STAT = 8'h08;
    localparam logic [7:0] REG_IRQ_MASK = 8'h0C;
    localparam logic [7:0] REG_LINE = 8'h10;
    localparam logic [7:0] REG_CMD = 8'h14;
    localparam logic [7:0] REG_MANUAL = 8'h18;
    localparam logic [7:0] REG_AUTO_SEL = 8'h1C;
    localparam logic [7:0] SLAVE_ADDR_RST = 8'h01;
    localparam logic [15:0] BAUD_DIV_RST = 16'h0823;
    localparam logic [7:0] TIMEOUT_RST = 8'h05;
    localparam logic [7:0] FC_COIL = 8'h05;
    localparam logic [7:0] FC_REG = 8'h06;
    localparam logic [7:0] FC_COILS = 8'h0F;
    localparam logic [7:0] FC_REGS = 8'h10;
    localparam logic [15:0] COIL_ON = 16'hFF00;
    localparam logic [15:0] CRC_POLY = 16'hA001;
    localparam int unsigned MAX_FRAME = 16;
    localparam int unsigned IRQ_OK = 0;
    localparam int unsigned IRQ_FAIL = 1;
    // ************************************************************
    // Carrier types
    // ************************************************************
    typedef struct packed {
        logic [15:0] baud_div;
        logic two_stop;
        logic seven_bits;
        logic [7:0] timeout_tenths;
        logic [7:0] slave_addr;
    } mbw_line_t;
    typedef struct packed {
        logic [7:0] func;
        logic [15:0] start;
        logic [7:0] count;
        logic manual;
        logic [2:0] src;
        logic [7:0] point;
    } mbw_cmd_t;
    typedef struct packed {
        logic [31:0] bit_flag_source;
        logic [31:0] input_image;
        logic [31:0] output_image;
        logic [15:0] analog_flag_source;
        logic [15:0] analog_output_image;
    } mbw_src_t;
    function automatic logic [15:0] mbw_crc_byte(input logic [15:0] crc, input logic [7:0] b);
        logic [15:0] c;
        c = crc ^ {8'h00, b};
        for (int i = 0; i < 8; i++) begin
            c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
        end
        return c;
    endfunction : mbw_crc_byte
endpackage : mbw_pkg

// ===== src/mbw_frame_mem.sv
// Small frame buffer holding the request bytes, registered read.
// Assumes one writer and one reader in the same clock.
`timescale 1ns/1ns
module mbw_frame_mem #(
    parameter int DEPTH = 16
) (
    // Clock
    input wire logic clk,
    // Write port
    input wire logic we,
    input wire logic [$clog2(DEPTH)-1:0] waddr,
    input wire logic [7:0] wdata,
    // Read port
    input wire logic [$clog2(DEPTH)-1:0] raddr,
    output logic [7:0] rdata
);
    logic [7:0] mem [DEPTH];
    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        rdata <= mem[raddr];
    end
endmodule : mbw_frame_mem

// ===== src/mbw_uart.sv
// Serial byte transmitter and receiver with settable rate, stop bits and data bits.
// Assumes the rx pin is already synchronous to clk; no parity.
`timescale 1ns/1ns
module mbw_uart (
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Line settings
    input wire mbw_pkg::mbw_line_t line,
    // Transmit byte
    input wire logic tx_valid,
    input wire logic [7:0] tx_data,
    output logic tx_ready,
    // Receive byte
    output logic rx_valid,
    output logic [7:0] rx_data,
    // Serial pins
    output logic txd,
    input wire logic rxd
);
    import mbw_pkg::*;
    logic [15:0] tcnt_q;
    logic [3:0] tbit_q;
    logic [10:0] tsh_q;
    logic tbusy_q;
    logic [15:0] rcnt_q;
    logic [3:0] rbit_q;
    logic [7:0] rsh_q;
    logic rbusy_q;
    logic [3:0] nbits;
    assign nbits = line.seven_bits ? 4'h7 : 4'h8;
    assign tx_ready = !tbusy_q;
    assign txd = tbusy_q ? tsh_q[0] : 1'b1;
    // Frame length = start + data + stops
    always_ff @(posedge clk) begin
        if (srst) begin
            tbusy_q <= 1'b0;
            tcnt_q <= 16'h0000;
            tbit_q <= 4'h0;
            tsh_q <= 11'h7FF;
        end else if (!tbusy_q) begin
            if (tx_valid) begin
                tbusy_q <= 1'b1;
                tcnt_q <= line.baud_div;
                tbit_q <= nbits + (line.two_stop ? 4'h2 : 4'h1);
                tsh_q <= line.seven_bits ? {3'h7, tx_data[6:0], 1'b0} : {2'h3, tx_data, 1'b0};
            end
        end else if (tcnt_q == 16'h0000) begin
            tcnt_q <= line.baud_div;
            tsh_q <= {1'b1, tsh_q[10:1]};
            if (tbit_q == 4'h0) begin
                tbusy_q <= 1'b0;
            end else begin
                tbit_q <= tbit_q - 4'h1;
            end
        end else begin
            tcnt_q <= tcnt_q - 16'h0001;
        end
    end
    // Receiver samples mid bit
    always_ff @(posedge clk) begin
        if (srst) begin
            rbusy_q <= 1'b0;
            rcnt_q <= 16'h0000;
            rbit_q <= 4'h0;
            rsh_q <= 8'h00;
            rx_valid <= 1'b0;
            rx_data <= 8'h00;
        end else begin
            rx_valid <= 1'b0;
            if (!rbusy_q) begin
                if (!rxd) begin
                    rbusy_q <= 1'b1;
                    rcnt_q <= {1'b0, line.baud_div[15:1]};
                    rbit_q <= 4'h0;
                end
            end else if (rcnt_q != 16'h0000) begin
                rcnt_q <= rcnt_q - 16'h0001;
            end else begin
                rcnt_q <= line.baud_div;
                if (rbit_q == 4'h0 && rxd) begin
                    rbusy_q <= 1'b0;
                end else if (rbit_q == nbits + 4'h1) begin
                    rbusy_q <= 1'b0;
                    rx_valid <= rxd;
                    rx_data <= line.seven_bits ? {1'b0, rsh_q[7:1]} : rsh_q;
                end else begin
                    if (rbit_q != 4'h0) begin
                        rsh_q <= {rxd, rsh_q[7:1]};
                    end
                    rbit_q <= rbit_q + 4'h1;
                end
            end
        end
    end
endmodule : mbw_uart

// ===== src/mbw_write_master.sv
// Modbus RTU write master: builds one write request, sends it, checks the echo reply.
// Assumes an AHB-Lite master, source images as synchronous inputs, and an external
// RS232 or RS485 driver on txd, with de high while a frame is on the wire.
//
// Design decisions made here: register access over AHB-Lite and the placing of the registers.
`timescale 1ns/1ns
module mbw_write_master #(
    parameter int unsigned TENTH_CYCLES = mbw_pkg::TENTH_CYCLES
) (
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Block inputs
    input wire logic enable,
    input wire logic block_reset,
    input wire mbw_pkg::mbw_src_t sources,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Serial side
    output logic txd,
    output logic de,
    input wire logic rxd,
    // Result
    output logic status,
    output logic irq
);
    import mbw_pkg::*;
    typedef enum {S_IDLE, S_BUILD, S_SEND, S_WAIT, S_DONE} mbw_state_t;
    mbw_state_t st_q;
    // ************************************************************
    // Register file
    // ************************************************************
    mbw_line_t line_q;
    mbw_cmd_t cmd_q;
    logic [31:0] manual_q;
    logic [1:0] irq_stat_q;
    logic [1:0] irq_mask_q;
    logic sw_go_q;
    logic ph_wr_q;
    logic [7:0] ph_addr_q;
    logic ev_ok;
    logic ev_fail;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    always_ff @(posedge clk) begin
        if (srst) begin
            ph_wr_q <= 1'b0;
            ph_addr_q <= 8'h00;
        end else if (hready) begin
            ph_wr_q <= hsel && htrans[1] && hwrite;
            ph_addr_q <= haddr[7:0];
        end
    end
    always_ff @(posedge clk) begin
        if (srst) begin
            line_q <= '{baud_div: BAUD_DIV_RST, two_stop: 1'b0, seven_bits: 1'b0,
                        timeout_tenths: TIMEOUT_RST, slave_addr: SLAVE_ADDR_RST};
            cmd_q <= '{func: FC_COIL, start: 16'h0000, count: 8'h01, manual: 1'b0, src: 3'h0, point: 8'h00};
            manual_q <= 32'h00000000;
            irq_mask_q <= 2'h0;
            sw_go_q <= 1'b0;
        end else if (ph_wr_q) begin
            case (ph_addr_q)
                REG_CTRL: sw_go_q <= hwdata[0];
                REG_IRQ_MASK: irq_mask_q <= hwdata[1:0];
                REG_LINE: line_q <= {2'b00, hwdata};
                REG_CMD: begin
                    cmd_q.func <= hwdata[7:0];
                    cmd_q.count <= hwdata[15:8];
                    cmd_q.start <= hwdata[31:16];
                end
                REG_MANUAL: manual_q <= hwdata;
                REG_AUTO_SEL: begin
                    cmd_q.point <= hwdata[7:0];
                    cmd_q.src <= hwdata[10:8];
                    cmd_q.manual <= hwdata[16];
                end
                default: ;
            endcase
        end
    end
    // Set wins over write-one-to-clear
    always_ff @(posedge clk) begin
        if (srst) begin
            irq_stat_q <= 2'h0;
        end else begin
            irq_stat_q <= (irq_stat_q & ~((ph_wr_q && ph_addr_q == REG_IRQ_STAT) ? hwdata[1:0] : 2'h0))
                | {ev_fail, ev_ok};
        end
    end
    assign irq = |(irq_stat_q & irq_mask_q);
    always_comb begin
        case (ph_addr_q)
            REG_CTRL: hrdata = {31'h0, sw_go_q};
            REG_STATUS: hrdata = {29'h0, st_q == S_WAIT, st_q != S_IDLE, status};
            REG_IRQ_STAT: hrdata = {30'h0, irq_stat_q};
            REG_IRQ_MASK: hrdata = {30'h0, irq_mask_q};
            REG_LINE: hrdata = line_q[31:0];
            REG_CMD: hrdata = {cmd_q.start, cmd_q.count, cmd_q.func};
            REG_MANUAL: hrdata = manual_q;
            REG_AUTO_SEL: hrdata = {15'h0, cmd_q.manual, 5'h0, cmd_q.src, cmd_q.point};
            default: hrdata = 32'h00000000;
        endcase
    end
    // ************************************************************
    // Data source
    // ************************************************************
    logic [31:0] data_w;
    logic [31:0] img;
    // Continuous point numbering lets the index address the image directly
    always_comb begin
        case (cmd_q.src)
            3'h0: img = sources.bit_flag_source >> cmd_q.point[4:0];
            3'h1: img = sources.input_image >> cmd_q.point[4:0];
            3'h2: img = sources.output_image >> cmd_q.point[4:0];
            3'h3: img = {16'h0, sources.analog_flag_source};
            default: img = {16'h0, sources.analog_output_image};
        endcase
        data_w = cmd_q.manual ? manual_q : img;
    end
    // ************************************************************
    // Frame build
    // ************************************************************
    logic [3:0] blen_q;
    logic [3:0] idx_q;
    logic [7:0] byte_w;
    logic [15:0] crc_q;
    logic [7:0] nbytes;
    logic [7:0] rd_byte;
    logic mem_we;
    logic [3:0] mem_waddr;
    logic [7:0] mem_wdata;
    assign nbytes = (cmd_q.func == FC_REGS) ? {cmd_q.count[6:0], 1'b0} : ((cmd_q.count + 8'h07) >> 3);
    // Multi-register payload is data_w high word first; registers past the second repeat data_w[7:0] in both bytes
    always_comb begin
        case (idx_q)
            4'h0: byte_w = line_q.slave_addr;
            4'h1: byte_w = cmd_q.func;
            4'h2: byte_w = cmd_q.start[15:8];
            4'h3: byte_w = cmd_q.start[7:0];
            4'h4: byte_w = (cmd_q.func == FC_COIL) ? (data_w[0] ? COIL_ON[15:8] : 8'h00) :
                (cmd_q.func == FC_REG) ? data_w[15:8] : 8'h00;
            4'h5: byte_w = (cmd_q.func == FC_COIL || cmd_q.func == FC_REG) ? data_w[7:0] & {8{cmd_q.func == FC_REG}}
                : cmd_q.count;
            4'h6: byte_w = nbytes;
            4'h7: byte_w = (cmd_q.func == FC_REGS) ? data_w[31:24] : data_w[7:0];
            4'h8: byte_w = (cmd_q.func == FC_REGS) ? data_w[23:16] : data_w[15:8];
            4'h9: byte_w = (cmd_q.func == FC_REGS) ? data_w[15:8] : data_w[23:16];
            default: byte_w = (cmd_q.func == FC_REGS) ? data_w[7:0] : data_w[31:24];
        endcase
    end
    assign mem_we = (st_q == S_BUILD) && (idx_q < blen_q);
    assign mem_waddr = idx_q;
    assign mem_wdata = (st_q == S_BUILD && idx_q == blen_q) ? crc_q[7:0] :
        (st_q == S_BUILD && idx_q == blen_q + 4'h1) ? crc_q[15:8] : byte_w;
    mbw_frame_mem #(.DEPTH(MAX_FRAME)) u_mem (
        .clk(clk),
        .we(mem_we || (st_q == S_BUILD && idx_q <= blen_q + 4'h1)),
        .waddr(mem_waddr),
        .wdata(mem_wdata),
        .raddr(idx_q),
        .rdata(rd_byte)
    );
    // ************************************************************
    // Sequencer
    // ************************************************************
    logic tx_valid_q;
    logic tx_ready;
    logic rx_valid;
    logic [7:0] rx_data;
    logic [3:0] rxn_q;
    logic [15:0] rcrc_q;
    logic [31:0] tcnt_q;
    logic [7:0] tenths_q;
    logic run;
    assign run = (enable || sw_go_q) && !block_reset;
    mbw_uart u_uart (
        .clk(clk),
        .srst(srst || block_reset),
        .line(line_q),
        .tx_valid(tx_valid_q),
        .tx_data(rd_byte),
        .tx_ready(tx_ready),
        .rx_valid(rx_valid),
        .rx_data(rx_data),
        .txd(txd),
        .rxd(rxd)
    );
    assign de = (st_q == S_SEND) || !tx_ready;
    assign ev_ok = (st_q == S_WAIT) && rx_valid && rxn_q == 4'h7 && mbw_crc_byte(rcrc_q, rx_data) == 16'h0000;
    assign ev_fail = (st_q == S_WAIT) && ((tenths_q <= 8'h01 && tcnt_q == 32'h0)
        || (rx_valid && rxn_q == 4'h1 && rx_data != cmd_q.func)
        || (rx_valid && rxn_q == 4'h7 && !ev_ok));
    always_ff @(posedge clk) begin
        if (srst || block_reset) begin
            st_q <= S_IDLE;
            status <= 1'b0;
            idx_q <= 4'h0;
            blen_q <= 4'h0;
            crc_q <= 16'hFFFF;
            tx_valid_q <= 1'b0;
            rxn_q <= 4'h0;
            rcrc_q <= 16'hFFFF;
            tcnt_q <= 32'h0;
            tenths_q <= 8'h00;
        end else begin
            case (st_q)
                S_IDLE: if (run) begin
                    st_q <= S_BUILD;
                    idx_q <= 4'h0;
                    crc_q <= 16'hFFFF;
                    blen_q <= (cmd_q.func == FC_COILS || cmd_q.func == FC_REGS) ? 4'h7 + nbytes[3:0] : 4'h6;
                end
                S_BUILD: begin
                    if (idx_q < blen_q) begin
                        crc_q <= mbw_crc_byte(crc_q, byte_w);
                    end
                    if (idx_q == blen_q + 4'h1) begin
                        st_q <= S_SEND;
                        idx_q <= 4'h0;
                    end else begin
                        idx_q <= idx_q + 4'h1;
                    end
                end
                S_SEND: begin
                    tx_valid_q <= 1'b0;
                    if (tx_ready && !tx_valid_q) begin
                        if (idx_q == blen_q + 4'h2) begin
                            st_q <= S_WAIT;
                            rxn_q <= 4'h0;
                            rcrc_q <= 16'hFFFF;
                            tenths_q <= line_q.timeout_tenths;
                            tcnt_q <= TENTH_CYCLES - 1;
                        end else begin
                            tx_valid_q <= 1'b1;
                            idx_q <= idx_q + 4'h1;
                        end
                    end
                end
                S_WAIT: begin
                    if (tcnt_q == 32'h0) begin
                        tcnt_q <= TENTH_CYCLES - 1;
                        tenths_q <= tenths_q - 8'h01;
                    end else begin
                        tcnt_q <= tcnt_q - 32'h1;
                    end
                    if (rx_valid) begin
                        rxn_q <= rxn_q + 4'h1;
                        rcrc_q <= mbw_crc_byte(rcrc_q, rx_data);
                    end
                    if (ev_ok) begin
                        status <= 1'b1;
                        st_q <= S_DONE;
                    end else if (ev_fail) begin
                        status <= 1'b0;
                        st_q <= S_DONE;
                    end
                end
                S_DONE: if (!run) begin
                    st_q <= S_IDLE;
                end
                default: st_q <= S_IDLE;
            endcase
        end
    end
endmodule : mbw_write_master

// ===== verification/mbw_slave_model.sv
// Behavioural remote station: receives one request frame, then echoes the reply.
// Assumes 8 data bits, one stop bit, no parity, and bit_cycles clocks per bit.
`timescale 1ns/1ns
module mbw_slave_model (
    // Clock
    input wire logic clk,
    // Settings from the bench
    input wire logic [15:0] bit_cycles,
    input wire logic respond,
    // Serial pins
    input wire logic txd,
    output logic rxd
);
    logic [7:0] rx_bytes [0:15];
    logic [15:0] c;
    logic crc_ok;
    int rx_len, last_len, frames, gap;
    function automatic logic [15:0] crc16(input int n);
        logic [15:0] r;
        r = 16'hFFFF;
        for (int i = 0; i < n; i++) begin
            r = r ^ {8'h00, rx_bytes[i]};
            for (int k = 0; k < 8; k++) begin
                r = r[0] ? ((r >> 1) ^ 16'hA001) : (r >> 1);
            end
        end
        return r;
    endfunction : crc16
    task automatic get_byte(output logic [7:0] b);
        repeat (bit_cycles / 2) @(posedge clk);
        for (int i = 0; i < 8; i++) begin
            repeat (bit_cycles) @(posedge clk);
            b[i] = txd;
        end
        repeat (bit_cycles) @(posedge clk);
    endtask : get_byte
    task automatic put_byte(input logic [7:0] b);
        logic [9:0] w;
        w = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            rxd <= w[i];
            repeat (bit_cycles) @(posedge clk);
        end
    endtask : put_byte
    initial begin
        rxd = 1'b1;
        rx_len = 0;
        last_len = 0;
        frames = 0;
        gap = 0;
        crc_ok = 1'b0;
        forever begin
            @(posedge clk);
            if (txd === 1'b0) begin
                get_byte(rx_bytes[rx_len]);
                rx_len++;
                gap = 0;
            end else if (rx_len > 0) begin
                gap++;
                if (gap > 12 * bit_cycles) begin
                    last_len = rx_len;
                    crc_ok = (crc16(rx_len) == 16'h0000);
                    rx_len = 0;
                    frames++;
                    if (respond) begin
                        c = crc16(6);
                        for (int i = 0; i < 6; i++) put_byte(rx_bytes[i]);
                        put_byte(c[7:0]);
                        put_byte(c[15:8]);
                    end
                end
            end
        end
    end
endmodule : mbw_slave_model

// ===== verification/mbw_write_master_props.sv
// Checker of the write master's pin-level behaviour: serial line, status, bus response.
// Assumes it is bound to mbw_write_master and sees only that module's ports.
`timescale 1ns/1ns
module mbw_write_master_props #(
    parameter int unsigned TENTH_CYCLES = mbw_pkg::TENTH_CYCLES
) (
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Block inputs
    input wire logic block_reset,
    // Bus response
    input wire logic hreadyout,
    input wire logic hresp,
    // Serial side and result
    input wire logic txd,
    input wire logic de,
    input wire logic status,
    input wire logic irq
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    // ************************************************************
    // Sequences
    // ************************************************************
    sequence s_send_begin;
        $rose(de);
    endsequence
    sequence s_start_bit;
        ##[0:16] !txd;
    endsequence
    property p_frame_start;
        s_send_begin |-> s_start_bit;
    endproperty
    // ************************************************************
    // Assertions
    // ************************************************************
    a_line_idle_high: assert property (!de |-> txd)
        else $error("serial line not idle high while the driver is off");
    a_frame_starts: assert property (p_frame_start)
        else $error("no start bit after the driver was enabled");
    a_srst_clears: assert property (disable iff (1'b0) srst |=> !status && !de && !irq && txd)
        else $error("outputs not cleared by the system reset");
    a_reset_clears: assert property (block_reset |=> !status)
        else $error("status not cleared by the block reset");
    a_reset_silences: assert property (block_reset [*3] |-> !de)
        else $error("frame sent while the block reset is held");
    a_status_rise_quiet: assert property ($rose(status) |-> !de && !block_reset)
        else $error("status set while sending or in reset");
    a_status_fall_cause: assert property ($fell(status) |-> !de || $past(block_reset))
        else $error("status cleared in the middle of a frame");
    a_bus_always_okay: assert property (hreadyout && !hresp)
        else $error("bus response not ready and okay");
endmodule : mbw_write_master_props

// ===== verification/mbw_write_master_tb.sv
// Self-checking bench of the write master with a behavioural remote station.
// Assumes a 20 MHz clock and a shortened tenth-of-a-second count.
`timescale 1ns/1ns
module mbw_write_master_tb;
    import mbw_pkg::*;
    localparam int unsigned TC = 200;
    logic clk, srst, enable, block_reset, hsel, hwrite, hreadyout, hresp, txd, de, rxd, status, irq, respond;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans;
    logic [2:0] hsize;
    mbw_src_t sources;
    int n_mismatch, samples_checked;
    mbw_write_master #(.TENTH_CYCLES(TC)) mbw_write_master_inst (.clk(clk), .srst(srst), .enable(enable),
        .block_reset(block_reset), .sources(sources), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .txd(txd), .de(de), .rxd(rxd), .status(status), .irq(irq));
    mbw_slave_model mbw_slave_model_inst (.clk(clk), .bit_cycles(16'h0009), .respond(respond), .txd(txd),
        .rxd(rxd));
    task test_done;
        $display("mismatches %0d, comparisons %0d", n_mismatch, samples_checked);
        if (n_mismatch == 0 && samples_checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : test_done
    task check(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    // One single transfer; the address phase is held until hready is seen high
    task ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        hsel <= 1'b1; htrans <= 2'b10; haddr <= {24'h000000, a}; hwrite <= w; hsize <= 3'b010;
        @(posedge clk);
        while (!hreadyout) @(posedge clk);
        htrans <= 2'b00; hwdata <= wd;
        @(posedge clk);
        while (!hreadyout) @(posedge clk);
        rd = hrdata;
    endtask : ahb
    task exch(input logic [31:0] cmd, input logic [31:0] sel, input logic [31:0] man, input logic ok,
              input logic [7:0] exp[$]);
        int f;
        ahb(1'b1, REG_CMD, cmd);
        ahb(1'b1, REG_AUTO_SEL, sel);
        ahb(1'b1, REG_MANUAL, man);
        f = mbw_slave_model_inst.frames;
        respond <= ok;
        enable <= 1'b1;
        wait (mbw_slave_model_inst.frames != f);
        rd = 32'h00000004;
        for (int i = 0; i < 1000 && rd[2]; i++) ahb(1'b0, REG_STATUS, 32'h0);
        check(rd[2], 1'b0);
        enable <= 1'b0;
        @(posedge clk);
        check(mbw_slave_model_inst.last_len, exp.size() + 2);
        for (int i = 0; i < exp.size(); i++) check(mbw_slave_model_inst.rx_bytes[i], exp[i]);
        check(mbw_slave_model_inst.crc_ok, 1'b1);
        check(status, ok);
    endtask : exch
    task t_reset_values;
        ahb(1'b0, REG_LINE, 32'h0);
        check(rd, 32'h208C0501);
        ahb(1'b0, REG_STATUS, 32'h0);
        check(rd, 32'h0);
        ahb(1'b0, 8'h40, 32'h0);
        check(rd, 32'h0);
        ahb(1'b1, REG_LINE, 32'h00200501);
        ahb(1'b1, REG_IRQ_MASK, 32'h00000002);
    endtask : t_reset_values
    task t_codes;
        exch(32'h0003_0105, 32'h00010000, 32'h5, 1'b1, '{8'h01, 8'h05, 8'h00, 8'h03, 8'hFF, 8'h00});
        exch(32'h0003_0106, 32'h00010000, 32'h5, 1'b1, '{8'h01, 8'h06, 8'h00, 8'h03, 8'h00, 8'h05});
        exch(32'h0003_030F, 32'h00010000, 32'h5, 1'b1,
             '{8'h01, 8'h0F, 8'h00, 8'h03, 8'h00, 8'h03, 8'h01, 8'h05});
        exch(32'h0003_0210, 32'h00010000, 32'h5, 1'b1,
             '{8'h01, 8'h10, 8'h00, 8'h03, 8'h00, 8'h02, 8'h04, 8'h00, 8'h00, 8'h00, 8'h05});
        check(irq, 1'b0);
    endtask : t_codes
    task t_auto_source;
        ahb(1'b1, REG_LINE, 32'h00220501);
        sources <= '{input_image: 32'h00000004, default: '0};
        exch(32'h0003_0105, 32'h00000102, 32'h0, 1'b1, '{8'h01, 8'h05, 8'h00, 8'h03, 8'hFF, 8'h00});
    endtask : t_auto_source
    task t_block_reset;
        block_reset <= 1'b1;
        enable <= 1'b1;
        repeat (40) @(posedge clk);
        check(status, 1'b0);
        check(de, 1'b0);
        block_reset <= 1'b0;
        enable <= 1'b0;
        @(posedge clk);
    endtask : t_block_reset
    task t_timeout_irq;
        exch(32'h0003_0105, 32'h00010000, 32'h0, 1'b0, '{8'h01, 8'h05, 8'h00, 8'h03, 8'h00, 8'h00});
        check(irq, 1'b1);
        ahb(1'b0, REG_IRQ_STAT, 32'h0);
        check(rd, 32'h00000003);
        ahb(1'b1, REG_IRQ_STAT, 32'h00000003);
        @(posedge clk);
        check(irq, 1'b0);
    endtask : t_timeout_irq
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // Whole run needs about 10500 cycles; nearly six times that means a hang
    initial begin
        repeat (60000) @(posedge clk);
        n_mismatch++;
        test_done();
    end
    initial begin
        n_mismatch = 0; samples_checked = 0; srst = 1'b1; enable = 1'b0; block_reset = 1'b0; respond = 1'b1;
        sources = '0; hsel = 1'b0; haddr = '0; htrans = 2'b00; hwrite = 1'b0; hsize = 3'b010; hwdata = '0;
        repeat (20) @(posedge clk);
        srst <= 1'b0;
        t_reset_values();
        t_codes();
        t_auto_source();
        t_block_reset();
        t_timeout_irq();
        test_done();
    end
endmodule : mbw_write_master_tb
bind mbw_write_master mbw_write_master_props #(.TENTH_CYCLES(TENTH_CYCLES)) props_inst (.clk(clk), .srst(srst),
    .block_reset(block_reset), .hreadyout(hreadyout), .hresp(hresp), .txd(txd), .de(de), .status(status),
    .irq(irq));
